// ---- scbc_pkg.sv ----
// Constants and types shared by the command and bank control block.
// Assumes one clock domain; every user writes scbc_pkg::name.
package scbc_pkg;
  localparam int ROW_BITS      = 11;
  localparam int COL_BITS      = 8;
  localparam int DATA_BITS     = 16;
  localparam int BYTE_BITS     = 8;
  localparam int BANK_COUNT    = 2;
  localparam int ALL_BANKS_BIT = 10;
  localparam int BL_LSB        = 0;
  localparam int BL_WIDTH      = 3;
  localparam int BUF_DEPTH     = 2;
  localparam logic [3:0] BURST_MAX = 4'h8;

  typedef enum logic [2:0] {
    CMD_IDLE,
    CMD_MODE_SET,
    CMD_REFRESH,
    CMD_PRECHARGE,
    CMD_ACTIVATE,
    CMD_WRITE,
    CMD_READ,
    CMD_BURST_STOP
  } scbc_cmd_t;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DOWN,
    PWR_SUSPEND,
    PWR_SELF_REFRESH
  } scbc_pwr_t;
endpackage

// ---- scbc_bank.sv ----
// Open or closed state and latched row of one bank.
// Assumes activate and precharge are same-clock pulses.
`timescale 1ns/1ps
module scbc_bank #(
  parameter int ROW_BITS = scbc_pkg::ROW_BITS
) (
  input  wire logic                clk,
  input  wire logic                rstN,
  input  wire logic                activate,
  input  wire logic                precharge,
  input  wire logic [ROW_BITS-1:0] rowIn,
  output logic                     open_q,
  output logic      [ROW_BITS-1:0] row_q
);
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      open_q <= 1'b0;
      row_q  <= '0;
    end
    else if (activate)
    begin
      open_q <= 1'b1;
      row_q  <= rowIn;
    end
    else if (precharge)
    begin
      open_q <= 1'b0;
    end
  end

  property p_bank_precharge_closes;
    @(posedge clk) disable iff (!rstN)
      (precharge && !activate) |=> !open_q;
  endproperty
  a_bank_precharge_closes: assert property (p_bank_precharge_closes)
    else $error("Bank stayed open after precharge.");
endmodule

// ---- scbc_skid.sv ----
// Small FIFO with valid and ready on both sides in the read data path.
// Assumes DEPTH is a power of two of at least two.
`timescale 1ns/1ps
module scbc_skid #(
  parameter int WIDTH = scbc_pkg::DATA_BITS,
  parameter int DEPTH = scbc_pkg::BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_check
    $error("Buffer depth must be a power of two of at least two.");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [PW:0]      count_q;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;

  assign inReady  = count_q != (PW+1)'(DEPTH);
  assign outValid = count_q != '0;
  assign outData  = store[rdPtr_q];

  always_ff @(posedge clk)
  begin
    if (push)
      store[wrPtr_q] <= inData;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_q + PW'(push);
      rdPtr_q <= rdPtr_q + PW'(pop);
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  property p_skid_full_holds;
    @(posedge clk) disable iff (!rstN)
      (!inReady && !outReady) |=> !inReady;
  endproperty
  a_skid_full_holds: assert property (p_skid_full_holds)
    else $error("Full buffer lost an entry without a drain.");
endmodule

// ---- scbc_top.sv ----
// Command decoding, bank and row control, byte masking and mode
// register of a two-bank, 16-bit synchronous DRAM.
// Assumes pins come from another clock domain and are synchronised here.
// Operation
// - Eleven address bits give the row; the low eight give the column.
// - Bank select picks the bank to open or to access.
// - Chip select high ignores new commands; a running burst continues.
// - Every rising edge samples inputs; row, column and write strobes decode together.
// - Read byte mask sampled high floats that byte two cycles later.
// - Write byte mask sampled high blocks that byte at once.
// - Clock gate low enters power down, suspend or self refresh.
// - Mode register resets to zero; accesses are refused until it is programmed.
// - All four strobes low sets the mode register from the address.
// - Row strobe high, column strobe low accesses; write strobe chooses.
// - Reads and writes may come every cycle, any open bank.
// - Precharge closes one bank, or all when address bit ten is high.
`timescale 1ns/1ps
module scbc_top #(
  parameter int ROW_BITS = scbc_pkg::ROW_BITS,
  parameter int COL_BITS = scbc_pkg::COL_BITS
) (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           chipSelN,
  input  wire logic                           rowStrobeN,
  input  wire logic                           colStrobeN,
  input  wire logic                           writeStrobeN,
  input  wire logic                           clockGate,
  input  wire logic                           bankSel,
  input  wire logic [ROW_BITS-1:0]            address_bits,
  input  wire logic                           upper_byte_mask,
  input  wire logic                           lower_byte_mask,
  input  wire logic [scbc_pkg::DATA_BITS-1:0] dataLinesIn,
  output logic      [scbc_pkg::DATA_BITS-1:0] dataLinesOut_q,
  output logic                                upperDriveN_q,
  output logic                                lowerDriveN_q,
  output logic      [ROW_BITS-1:0]            modeWord_q,
  output logic                                modeProgrammed_q,
  output scbc_pkg::scbc_pwr_t                 powerState_q,
  output logic      [1:0]                     bankOpen
);
  localparam int DW    = scbc_pkg::DATA_BITS;
  localparam int BB    = scbc_pkg::BYTE_BITS;
  localparam int PIN_W = 8 + ROW_BITS + DW;
  localparam int IDX_W = 1 + ROW_BITS + COL_BITS;

  if (COL_BITS < 4 || COL_BITS > ROW_BITS || ROW_BITS <= 10)
  begin : g_check
    $error("Column bits must be 4..ROW_BITS and ROW_BITS above 10.");
  end

  // Reset release through two flip-flops.
  logic [1:0] rstPipe_q;
  wire        rstN = rstPipe_q[1];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rstPipe_q <= 2'h0;
    else
      rstPipe_q <= {rstPipe_q[0], 1'b1};
  end

  // Two-stage synchroniser for every pin input.
  logic [PIN_W-1:0] pinSync1_q;
  logic [PIN_W-1:0] pinSync2_q;
  localparam logic [PIN_W-1:0] PIN_IDLE = {6'h3E, {ROW_BITS{1'b0}}, 2'h3,
                                           {DW{1'b0}}};
  wire  [PIN_W-1:0] pinRaw = {chipSelN, rowStrobeN, colStrobeN, writeStrobeN,
                              clockGate, bankSel, address_bits,
                              upper_byte_mask, lower_byte_mask, dataLinesIn};

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pinSync1_q <= PIN_IDLE;
      pinSync2_q <= PIN_IDLE;
    end
    else
    begin
      pinSync1_q <= pinRaw;
      pinSync2_q <= pinSync1_q;
    end
  end

  logic                csS;
  logic                rasS;
  logic                casS;
  logic                weS;
  logic                ckeS;
  logic                bankS;
  logic [ROW_BITS-1:0] addrS;
  logic                upperMaskS;
  logic                lowerMaskS;
  logic [DW-1:0]       dataS;

  assign {csS, rasS, casS, weS, ckeS, bankS, addrS,
          upperMaskS, lowerMaskS, dataS} = pinSync2_q;

  // Command decode from the three strobes, gated by chip select.
  wire [2:0] strobes = {rasS, casS, weS};
  scbc_pkg::scbc_cmd_t cmd;
  assign cmd = csS               ? scbc_pkg::CMD_IDLE :
               strobes == 3'h0   ? scbc_pkg::CMD_MODE_SET :
               strobes == 3'h1   ? scbc_pkg::CMD_REFRESH :
               strobes == 3'h2   ? scbc_pkg::CMD_PRECHARGE :
               strobes == 3'h3   ? scbc_pkg::CMD_ACTIVATE :
               strobes == 3'h4   ? scbc_pkg::CMD_WRITE :
               strobes == 3'h5   ? scbc_pkg::CMD_READ :
               strobes == 3'h6   ? scbc_pkg::CMD_BURST_STOP :
                                   scbc_pkg::CMD_IDLE;

  wire run     = ckeS && powerState_q == scbc_pkg::PWR_RUN;
  wire isAct   = run && cmd == scbc_pkg::CMD_ACTIVATE;
  wire isPre   = run && cmd == scbc_pkg::CMD_PRECHARGE;
  wire isMode  = run && cmd == scbc_pkg::CMD_MODE_SET;
  wire isStop  = run && cmd == scbc_pkg::CMD_BURST_STOP;
  wire isRdWr  = run && (cmd == scbc_pkg::CMD_READ ||
                         cmd == scbc_pkg::CMD_WRITE);

  // Bank state, one instance per bank.
  logic [ROW_BITS-1:0] bankRow [2];

  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    wire hit = bankS == 1'(b);
    scbc_bank #(
      .ROW_BITS (ROW_BITS)
    ) u_bank (
      .clk       (clk),
      .rstN      (rstN),
      .activate  (isAct && hit && !bankOpen[b]),
      .precharge (isPre && (addrS[scbc_pkg::ALL_BANKS_BIT] || hit)),
      .rowIn     (addrS),
      .open_q    (bankOpen[b]),
      .row_q     (bankRow[b])
    );
  end

  // Burst length from the mode register: codes 0..3 give 1, 2, 4, 8.
  wire [scbc_pkg::BL_WIDTH-1:0] blCode =
    modeWord_q[scbc_pkg::BL_LSB +: scbc_pkg::BL_WIDTH];
  wire [3:0] burstLen = blCode > 3'h3 ? 4'h1 : 4'(4'h1 << blCode[1:0]);

  // Burst sequencing; a new access overrides a running burst.
  logic                burstBank_q;
  logic [COL_BITS-1:0] burstCol_q;
  logic [3:0]          burstLeft_q;
  logic                burstWrite_q;
  logic                bufInReady;

  wire isAccess = isRdWr && bankOpen[bankS] && modeProgrammed_q;
  wire                effBank  = isAccess ? bankS : burstBank_q;
  wire [COL_BITS-1:0] effCol   = isAccess ? addrS[COL_BITS-1:0] : burstCol_q;
  wire                effWrite = isAccess ? cmd == scbc_pkg::CMD_WRITE
                                          : burstWrite_q;
  wire [3:0]          effLeft  = isAccess ? burstLen :
                                 (isStop || !bankOpen[effBank]) ? 4'h0 :
                                 burstLeft_q;
  // Suspend holds the burst; a full buffer stalls reads.
  wire doWord = run && effLeft != 4'h0 && (effWrite || bufInReady);
  wire [COL_BITS-1:0] wrap    = {{(COL_BITS-4){1'b0}}, burstLen - 4'h1};
  wire [COL_BITS-1:0] nextCol = (effCol & ~wrap) |
                                (COL_BITS'(effCol + 1'b1) & wrap);
  wire burstActive = burstLeft_q != 4'h0;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      burstBank_q  <= 1'b0;
      burstCol_q   <= '0;
      burstLeft_q  <= 4'h0;
      burstWrite_q <= 1'b0;
    end
    else
    begin
      burstBank_q  <= effBank;
      burstCol_q   <= doWord ? nextCol : effCol;
      burstLeft_q  <= doWord ? effLeft - 4'h1 : effLeft;
      burstWrite_q <= effWrite;
    end
  end

  // Storage array addressed by bank, open row and column.
  logic [DW-1:0]    mem [1 << IDX_W];
  wire  [IDX_W-1:0] memIdx = {effBank, bankRow[effBank], effCol};
  wire              wrLow  = doWord && effWrite && !lowerMaskS;
  wire              wrHigh = doWord && effWrite && !upperMaskS;

  always_ff @(posedge clk)
  begin
    if (wrLow)
      mem[memIdx][BB-1:0] <= dataS[BB-1:0];
    if (wrHigh)
      mem[memIdx][DW-1:BB] <= dataS[DW-1:BB];
  end

  // Read words queue here; clock suspend stalls the drain.
  logic          bufOutValid;
  logic [DW-1:0] bufOutData;

  scbc_skid #(
    .WIDTH (DW),
    .DEPTH (scbc_pkg::BUF_DEPTH)
  ) u_skid (
    .clk      (clk),
    .rstN     (rstN),
    .inValid  (doWord && !effWrite),
    .inData   (mem[memIdx]),
    .inReady  (bufInReady),
    .outValid (bufOutValid),
    .outData  (bufOutData),
    .outReady (ckeS)
  );

  // Output stage; masks sampled now float their byte two cycles later.
  logic [1:0] maskHold_q;
  wire        popNow = bufOutValid && ckeS;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      maskHold_q     <= 2'h3;
      dataLinesOut_q <= '0;
      upperDriveN_q  <= 1'b1;
      lowerDriveN_q  <= 1'b1;
    end
    else
    begin
      maskHold_q     <= {upperMaskS, lowerMaskS};
      dataLinesOut_q <= popNow ? bufOutData : dataLinesOut_q;
      upperDriveN_q  <= !popNow || maskHold_q[1];
      lowerDriveN_q  <= !popNow || maskHold_q[0];
    end
  end

  // Mode register, written only with every bank closed.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      modeWord_q       <= '0;
      modeProgrammed_q <= 1'b0;
    end
    else if (isMode && bankOpen == 2'h0)
    begin
      modeWord_q       <= addrS;
      modeProgrammed_q <= 1'b1;
    end
  end

  // Power state from the clock gate and the current activity.
  scbc_pkg::scbc_pwr_t powerNext;
  wire srEntry = !csS && cmd == scbc_pkg::CMD_REFRESH;
  assign powerNext = ckeS ? scbc_pkg::PWR_RUN :
                     powerState_q != scbc_pkg::PWR_RUN ? powerState_q :
                     burstActive ? scbc_pkg::PWR_SUSPEND :
                     srEntry ? scbc_pkg::PWR_SELF_REFRESH :
                               scbc_pkg::PWR_DOWN;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      powerState_q <= scbc_pkg::PWR_RUN;
    else
      powerState_q <= powerNext;
  end

  // Helper state read only by the checks below.
  logic [IDX_W-1:0] lastIdx_q;
  always_ff @(posedge clk)
  begin
    lastIdx_q <= memIdx;
  end
  wire [BB-1:0] oldLow = mem[memIdx][BB-1:0];

  property p_read_mask_float;
    @(posedge clk) disable iff (!rstN)
      upperMaskS |=> ##1 upperDriveN_q;
  endproperty
  a_read_mask_float: assert property (p_read_mask_float)
    else $error("Masked upper byte was driven two cycles later.");

  property p_write_mask_block;
    @(posedge clk) disable iff (!rstN)
      (doWord && effWrite && lowerMaskS) |=>
        mem[lastIdx_q][BB-1:0] == $past(oldLow);
  endproperty
  a_write_mask_block: assert property (p_write_mask_block)
    else $error("Masked lower byte was written.");

  property p_deselect_ignored;
    @(posedge clk) disable iff (!rstN)
      csS |=> $stable(bankOpen) && $stable(modeWord_q);
  endproperty
  a_deselect_ignored: assert property (p_deselect_ignored)
    else $error("Command taken while chip select was high.");

  property p_precharge_all;
    @(posedge clk) disable iff (!rstN)
      (run && !csS && strobes == 3'h2 && addrS[scbc_pkg::ALL_BANKS_BIT])
        |=> bankOpen == 2'h0;
  endproperty
  a_precharge_all: assert property (p_precharge_all)
    else $error("Precharge of all banks left a bank open.");

  property p_mode_set;
    @(posedge clk) disable iff (!rstN)
      (isMode && bankOpen == 2'h0) |=>
        modeProgrammed_q && modeWord_q == $past(addrS);
  endproperty
  a_mode_set: assert property (p_mode_set)
    else $error("Mode register did not take the address.");

  property p_gate_low_leaves_run;
    @(posedge clk) disable iff (!rstN)
      !ckeS |=> powerState_q != scbc_pkg::PWR_RUN;
  endproperty
  a_gate_low_leaves_run: assert property (p_gate_low_leaves_run)
    else $error("Clock gate low did not leave the run state.");

  property p_unprogrammed_quiet;
    @(posedge clk) disable iff (!rstN)
      (!modeProgrammed_q && !bufOutValid) |=> upperDriveN_q && lowerDriveN_q;
  endproperty
  a_unprogrammed_quiet: assert property (p_unprogrammed_quiet)
    else $error("Data driven before the mode register was set.");

  property p_activate_row;
    @(posedge clk) disable iff (!rstN)
      (isAct && !bankOpen[bankS]) |=>
        bankOpen[$past(bankS)] && bankRow[$past(bankS)] == $past(addrS);
  endproperty
  a_activate_row: assert property (p_activate_row)
    else $error("Activate did not latch the row into the bank.");

  property p_read_drives;
    @(posedge clk) disable iff (!rstN)
      (isAccess && cmd == scbc_pkg::CMD_READ && bufInReady &&
       !lowerMaskS) ##1 ckeS |=> !lowerDriveN_q;
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("Read word was not driven two cycles after the command.");
endmodule

// ---- scbc_ctl_model.sv ----
// Behavioural memory controller that drives the DRAM command and data pins.
// Assumes one caller at a time; pins change on the falling clock edge.
`timescale 1ns/1ps
module scbc_ctl_model #(
  parameter int INIT_CYC = 400,
  parameter int GAP      = 5
) (
  input  wire logic        clk,
  output logic             chipSelN,
  output logic             rowStrobeN,
  output logic             colStrobeN,
  output logic             writeStrobeN,
  output logic             clockGate,
  output logic             bankSel,
  output logic [10:0]      address_bits,
  output logic             upper_byte_mask,
  output logic             lower_byte_mask,
  output logic [15:0]      dataLinesIn
);
  localparam logic [2:0] MRS = 3'h0, REF = 3'h1, PRE = 3'h2, ACT = 3'h3;
  localparam logic [2:0] IDLE_COMMAND = 3'h7;
  logic        gateLvl;
  logic [1:0]  maskIdle;
  logic [1:0]  openQ;
  logic [10:0] rowQ [2];

  initial
  begin
    gateLvl = 1'b1;
    maskIdle = 2'b11;
    openQ = 2'b00;
    chipSelN = 1'b0;
    {rowStrobeN, colStrobeN, writeStrobeN} = IDLE_COMMAND;
    clockGate = 1'b1;
    bankSel = 1'b0;
    address_bits = 11'h000;
    {upper_byte_mask, lower_byte_mask} = 2'b11;
    dataLinesIn = 16'h0000;
  end

  // Drives one command for one cycle and tracks the open banks.
  task automatic cmd(input logic [2:0] c, input logic csN, input logic bk,
                     input logic [10:0] a, input logic [1:0] m,
                     input logic [15:0] d);
    @(negedge clk);
    chipSelN = csN;
    {rowStrobeN, colStrobeN, writeStrobeN} = c;
    clockGate = gateLvl;
    bankSel = bk;
    address_bits = a;
    {upper_byte_mask, lower_byte_mask} = m;
    dataLinesIn = d;
    if (!csN && gateLvl && c == ACT)
    begin
      openQ[bk] = 1'b1;
      rowQ[bk] = a;
    end
    if (!csN && gateLvl && c == PRE)
      openQ = a[10] ? 2'b00 : (openQ & ~(2'b01 << bk));
  endtask

  // Idle cycles; the released data lines show the inverse of the last word.
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge clk);
      chipSelN = 1'b0;
      {rowStrobeN, colStrobeN, writeStrobeN} = IDLE_COMMAND;
      clockGate = gateLvl;
      {upper_byte_mask, lower_byte_mask} = maskIdle;
      dataLinesIn = ~dataLinesIn;
    end
  endtask

  // Opens a row, closing another open row of that bank first.
  task automatic act(input logic bk, input logic [10:0] row);
    if (openQ[bk] && rowQ[bk] != row)
    begin
      cmd(PRE, 1'b0, bk, 11'h000, 2'b00, 16'h0000);
      idle(GAP);
    end
    if (!openQ[bk])
    begin
      cmd(ACT, 1'b0, bk, row, 2'b00, 16'h0000);
      idle(GAP);
    end
  endtask

  // Power-up pause with idle commands and masks held high.
  task automatic pause;
    idle(INIT_CYC);
    maskIdle = 2'b00;
  endtask

  // Precharge of all banks, eight refreshes, then the mode set.
  task automatic setup(input logic [10:0] mode);
    cmd(PRE, 1'b0, 1'b0, 11'h400, 2'b00, 16'h0000);
    idle(GAP);
    repeat (8)
    begin
      cmd(REF, 1'b0, 1'b0, 11'h000, 2'b00, 16'h0000);
      idle(GAP);
    end
    cmd(MRS, 1'b0, 1'b0, mode, 2'b00, 16'h0000);
    idle(GAP);
  endtask
endmodule

// ---- scbc_top_tb.sv ----
// Self-checking bench for the DRAM command and bank control block.
// Assumes the controller model drives every pin but clk and resetn; one 200 MHz clock.
`timescale 1ns/1ps
module scbc_top_tb;
  localparam int INIT_CYC = 400;
  localparam int GAP      = 5;
  localparam logic [2:0] MRS = 3'h0, REF = 3'h1, PRE = 3'h2, ACT = 3'h3;
  localparam logic [2:0] WR = 3'h4, RD = 3'h5, IDLE_COMMAND = 3'h7;
  logic                clk;
  logic                resetn;
  logic                chipSelN;
  logic                rowStrobeN;
  logic                colStrobeN;
  logic                writeStrobeN;
  logic                clockGate;
  logic                bankSel;
  logic [10:0]         address_bits;
  logic                upper_byte_mask;
  logic                lower_byte_mask;
  logic [15:0]         dataLinesIn;
  logic [15:0]         dataLinesOut_q;
  logic                upperDriveN_q;
  logic                lowerDriveN_q;
  logic [10:0]         modeWord_q;
  logic                modeProgrammed_q;
  scbc_pkg::scbc_pwr_t powerState_q;
  logic [1:0]          bankOpen;
  int                  failures;
  int                  checked;

  scbc_top dut (.clk(clk), .resetn(resetn), .chipSelN(chipSelN),
    .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .writeStrobeN(writeStrobeN), .clockGate(clockGate), .bankSel(bankSel),
    .address_bits(address_bits), .upper_byte_mask(upper_byte_mask),
    .lower_byte_mask(lower_byte_mask), .dataLinesIn(dataLinesIn),
    .dataLinesOut_q(dataLinesOut_q), .upperDriveN_q(upperDriveN_q),
    .lowerDriveN_q(lowerDriveN_q), .modeWord_q(modeWord_q),
    .modeProgrammed_q(modeProgrammed_q), .powerState_q(powerState_q),
    .bankOpen(bankOpen));

  scbc_ctl_model #(.INIT_CYC(INIT_CYC), .GAP(GAP)) ctl (.clk(clk),
    .chipSelN(chipSelN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .writeStrobeN(writeStrobeN), .clockGate(clockGate), .bankSel(bankSel),
    .address_bits(address_bits), .upper_byte_mask(upper_byte_mask),
    .lower_byte_mask(lower_byte_mask), .dataLinesIn(dataLinesIn));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_open(input logic [1:0] e);
    check("bankOpen", {14'h0000, bankOpen}, {14'h0000, e});
  endtask

  task automatic chk_pwr(input scbc_pkg::scbc_pwr_t e);
    check("powerState", {14'h0000, powerState_q}, {14'h0000, e});
  endtask

  // Issues a read and captures the first word that the device drives.
  task automatic read_check(input logic bk, input logic [10:0] a,
                            input logic [1:0] m, input logic [1:0] drv,
                            input logic [15:0] exp);
    logic [1:0]  seen;
    logic [15:0] word;
    logic [15:0] keep;
    seen = 2'b00;
    word = 16'h0000;
    keep = {{8{drv[1]}}, {8{drv[0]}}};
    ctl.cmd(RD, 1'b0, bk, a, m, 16'h0000);
    fork
      ctl.idle(10);
      repeat (10)
      begin
        @(posedge clk);
        #1;
        if (seen == 2'b00)
        begin
          seen = ~{upperDriveN_q, lowerDriveN_q};
          word = dataLinesOut_q;
        end
      end
    join
    check("read drive", {14'h0000, seen}, {14'h0000, drv});
    check("read word", word & keep, exp & keep);
  endtask

  task automatic t_reset;
    chk_open(2'b00);
    check("modeWord", {5'h00, modeWord_q}, 16'h0000);
    check("drive", {14'h0000, upperDriveN_q, lowerDriveN_q}, 16'h0003);
    chk_pwr(scbc_pkg::PWR_RUN);
  endtask

  task automatic t_init;
    ctl.pause();
    ctl.act(1'b0, 11'h005);
    check("modeProgrammed", {15'h0000, modeProgrammed_q}, 16'h0000);
    read_check(1'b0, 11'h007, 2'b00, 2'b00, 16'h0000);
    ctl.setup(11'h020);
    chk_open(2'b00);
    check("modeWord", {5'h00, modeWord_q}, 16'h0020);
    check("modeProgrammed", {15'h0000, modeProgrammed_q}, 16'h0001);
  endtask

  task automatic t_banks;
    ctl.act(1'b1, 11'h003);
    chk_open(2'b10);
    ctl.cmd(ACT, 1'b1, 1'b0, 11'h005, 2'b00, 16'h0000);
    ctl.idle(GAP);
    chk_open(2'b10);
    ctl.act(1'b0, 11'h405);
    chk_open(2'b11);
    ctl.cmd(MRS, 1'b0, 1'b0, 11'h031, 2'b00, 16'h0000);
    ctl.idle(GAP);
    check("modeWord", {5'h00, modeWord_q}, 16'h0020);
    ctl.cmd(PRE, 1'b0, 1'b1, 11'h000, 2'b00, 16'h0000);
    ctl.idle(GAP);
    chk_open(2'b01);
  endtask

  task automatic t_access;
    ctl.cmd(WR, 1'b0, 1'b0, 11'h007, 2'b00, 16'hA5C3);
    ctl.cmd(WR, 1'b0, 1'b0, 11'h008, 2'b00, 16'h1234);
    ctl.cmd(WR, 1'b0, 1'b0, 11'h007, 2'b01, 16'h5A3C);
    ctl.idle(GAP);
    read_check(1'b0, 11'h107, 2'b00, 2'b11, 16'h5AC3);
    read_check(1'b0, 11'h008, 2'b00, 2'b11, 16'h1234);
    read_check(1'b0, 11'h007, 2'b10, 2'b01, 16'h5AC3);
    ctl.act(1'b0, 11'h005);
    ctl.cmd(WR, 1'b0, 1'b0, 11'h007, 2'b00, 16'h0F0F);
    ctl.idle(GAP);
    read_check(1'b0, 11'h007, 2'b00, 2'b11, 16'h0F0F);
    ctl.act(1'b0, 11'h405);
    read_check(1'b0, 11'h007, 2'b00, 2'b11, 16'h5AC3);
  endtask

  task automatic t_burst;
    ctl.cmd(PRE, 1'b0, 1'b0, 11'h400, 2'b00, 16'h0000);
    ctl.idle(GAP);
    chk_open(2'b00);
    ctl.cmd(MRS, 1'b0, 1'b0, 11'h001, 2'b00, 16'h0000);
    ctl.idle(GAP);
    check("modeWord", {5'h00, modeWord_q}, 16'h0001);
    ctl.act(1'b1, 11'h002);
    ctl.cmd(WR, 1'b0, 1'b1, 11'h003, 2'b00, 16'hBEEF);
    ctl.cmd(IDLE_COMMAND, 1'b0, 1'b0, 11'h000, 2'b00, 16'hCAFE);
    ctl.idle(GAP);
    read_check(1'b1, 11'h002, 2'b00, 2'b11, 16'hCAFE);
    read_check(1'b1, 11'h003, 2'b00, 2'b11, 16'hBEEF);
  endtask

  task automatic t_power;
    ctl.gateLvl = 1'b0;
    ctl.cmd(ACT, 1'b0, 1'b0, 11'h009, 2'b00, 16'h0000);
    ctl.idle(GAP);
    chk_pwr(scbc_pkg::PWR_DOWN);
    chk_open(2'b10);
    ctl.gateLvl = 1'b1;
    ctl.idle(GAP);
    chk_pwr(scbc_pkg::PWR_RUN);
    ctl.gateLvl = 1'b0;
    ctl.cmd(REF, 1'b0, 1'b0, 11'h000, 2'b00, 16'h0000);
    ctl.idle(GAP);
    chk_pwr(scbc_pkg::PWR_SELF_REFRESH);
    ctl.gateLvl = 1'b1;
    ctl.idle(GAP);
    chk_pwr(scbc_pkg::PWR_RUN);
    ctl.cmd(RD, 1'b0, 1'b1, 11'h002, 2'b00, 16'h0000);
    ctl.gateLvl = 1'b0;
    ctl.idle(GAP);
    chk_pwr(scbc_pkg::PWR_SUSPEND);
    ctl.gateLvl = 1'b1;
    ctl.idle(GAP);
    chk_pwr(scbc_pkg::PWR_RUN);
    ctl.cmd(PRE, 1'b0, 1'b0, 11'h400, 2'b00, 16'h0000);
    ctl.idle(GAP);
    chk_open(2'b00);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (INIT_CYC + 4000) @(posedge clk);
    failures++;
    end_of_test();
  end

  initial
  begin
    failures = 0;
    checked = 0;
    resetn = 1'b0;
    repeat (20) @(negedge clk);
    t_reset();
    resetn = 1'b1;
    t_init();
    t_banks();
    t_access();
    t_burst();
    t_power();
    end_of_test();
  end
endmodule
